// >>> hw/lcd_cfg_params.svh
`ifndef LCD_CFG_PARAMS_SVH
`define LCD_CFG_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets on the apb window
// ----------------------------------------------------------------------
`define LCD_CLKS_OFF          12'h000
`define LCD_SUPPLY_OFF        12'h004
`define LCD_BLINK_OFF         12'h008

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LCD_CLKS_RST          8'h00
`define LCD_SUPPLY_RST        8'h00
`define LCD_BLINK_RST         8'h00

// ----------------------------------------------------------------------
// clock source register fields
// ----------------------------------------------------------------------
`define CLKS_SOURCE_BIT       7
`define CLKS_PRESCALE_BIT     6
`define CLKS_DIV_MSB          5
`define CLKS_DIV_LSB          0

// ----------------------------------------------------------------------
// supply register fields
// ----------------------------------------------------------------------
`define SUP_PUMP_EN_BIT       7
`define SUP_PUMP_MULT_BIT     6
`define SUP_PUMP_ADJ_MSB      5
`define SUP_PUMP_ADJ_LSB      4
`define SUP_HIGH_DRIVE_BIT    3
`define SUP_BYPASS_BIT        2
`define SUP_SOURCE_MSB        1
`define SUP_SOURCE_LSB        0

// ----------------------------------------------------------------------
// blink control register fields
// ----------------------------------------------------------------------
`define BLK_ENABLE_BIT        7
`define BLK_SCOPE_BIT         3
`define BLK_RATE_MSB          2
`define BLK_RATE_LSB          0

// ----------------------------------------------------------------------
// divider constants
// ----------------------------------------------------------------------
`define PRESCALE_DIV          16
`define PUMP_BASE_DIV         6
`define BLINK_EXP_BASE        5

`endif

// >>> hw/lcd_cfg_pkg.sv
package lcd_cfg_pkg;

    typedef logic [11:0] apb_addr_type;
    typedef logic [31:0] apb_data_type;

    typedef enum logic [0:0] {
        blink_off,
        blink_run
    } blink_state_type;

endpackage

// >>> hw/div_if.sv
`timescale 1ns/1ps

interface div_if #(
    parameter int W = 8
);
    logic         tick_in;
    logic         clear;
    logic [W-1:0] limit;
    logic         tick_out;

    modport stage (input tick_in, input clear, input limit, output tick_out);
    modport ctrl  (output tick_in, output clear, output limit, input tick_out);
endinterface

// >>> hw/div_stage.sv
`timescale 1ns/1ps

module div_stage #(
    parameter int W = 8
) (
    input  wire logic i_clk,   // system clock
    input  wire logic i_srst,  // sync reset, active high
    input  wire logic i_ce,    // clock enable
    div_if.stage      bus      // tick in, limit, tick out
);
    logic [W-1:0] cnt_r;
    logic         hit;

    // ">=" so that lowering the limit mid-count never strands the counter
    assign hit          = bus.tick_in && (cnt_r >= bus.limit);
    assign bus.tick_out = hit;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt_r <= '0;
        end else if (i_ce) begin
            if (bus.clear || hit) begin
                cnt_r <= '0;
            end else if (bus.tick_in) begin
                cnt_r <= cnt_r + W'(1);
            end
        end
    end
endmodule // div_stage

// >>> hw/lcd_cfg.sv
`timescale 1ns/1ps
`include "lcd_cfg_params.svh"

// How it works
// - bit 7 picks clock basis: 0 external reference, 1 bus clock (half generator output)
// - bit 6 set divides the selected source by 16 first
// - panel clock is source over prescale times divider field plus one
// - pump enable bit 7 turns pump on and forces internal third bias
// - supply bit 6 picks doubler (0) or tripler (1)
// - pump clock is panel clock over six times two to adjust plus one
// - supply bit 3 selects normal or high buffer drive
// - supply bit 2 keeps op amp buffer (0) or bypasses it (1)
// - supply bits 1:0 select internal or external panel supply
// - blink bit 7 starts or stops blinking at next frame start
// - scope bit 3: 0 blink-enabled segments only, 1 all; idle when off
// - blink rate is base clock over two to five plus rate
// - single-segment blink needs both on bit and blink-enable bit
// - module enable low leaves all segment outputs inactive

module lcd_cfg #(
    parameter int N_SEG = 164                           // segment count
) (
    input  wire logic                      i_clk,                    // system clock, generator output
    input  wire logic                      i_srst,                   // sync reset, active high
    input  wire logic                      i_ce,                     // clock enable, freezes all state
    input  wire logic                      i_psel,                   // apb select
    input  wire logic                      i_penable,                // apb enable
    input  wire logic                      i_pwrite,                 // apb direction
    input  wire lcd_cfg_pkg::apb_addr_type i_paddr,                  // apb byte address
    input  wire lcd_cfg_pkg::apb_data_type i_pwdata,                 // apb write data
    output lcd_cfg_pkg::apb_data_type      o_prdata,                 // apb read data
    output logic                           o_pready,                 // apb ready
    output logic                           o_pslverr,                // apb error, unmapped address
    input  wire logic                      i_external_reference_clock, // reference clock level
    input  wire logic                      i_panel_module_enable,    // module enable from command reg
    input  wire logic                      i_frame_start,            // pulse, first cycle of a frame
    input  wire logic                      i_wave_base_tick,         // pulse, waveform base clock
    input  wire logic [N_SEG-1:0]          i_seg_on,                 // on/off bank
    input  wire logic [N_SEG-1:0]          i_seg_blink_en,           // blink-enable bank
    output logic                           o_panel_clock_tick,       // pulse, panel clock
    output logic                           o_pump_clock_tick,        // pulse, charge pump clock
    output logic                           o_charge_pump_enable,     // pump on
    output logic                           o_bias_internal,          // internal third bias forced
    output logic                           o_pump_tripler,           // 1 tripler, 0 doubler
    output logic                           o_high_drive_buffer_select, // high buffer drive
    output logic                           o_buffer_bypass,          // op amp bypassed
    output logic [1:0]                     o_supply_source_select,   // supply source code
    output logic                           o_blink_active,           // blinking in force
    output logic                           o_blink_phase,            // 1 blanked half period
    output logic [N_SEG-1:0]               o_seg_drive               // segment shown
);
    import lcd_cfg_pkg::*;

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [7:0] clks_r;
    logic [7:0] supply_r;
    logic [7:0] blink_ctl_r;
    logic       wr;
    logic       hit_clks;
    logic       hit_supply;
    logic       hit_blink;
    logic       mapped;

    assign hit_clks   = (i_paddr == `LCD_CLKS_OFF);
    assign hit_supply = (i_paddr == `LCD_SUPPLY_OFF);
    assign hit_blink  = (i_paddr == `LCD_BLINK_OFF);
    assign mapped     = hit_clks || hit_supply || hit_blink;
    // ready follows the clock enable so a frozen block stalls the bus
    assign o_pready   = i_ce;
    assign wr         = i_psel && i_penable && i_ce && i_pwrite && mapped;
    assign o_pslverr  = i_psel && i_penable && !mapped;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            clks_r      <= `LCD_CLKS_RST;
            supply_r    <= `LCD_SUPPLY_RST;
            blink_ctl_r <= `LCD_BLINK_RST;
        end else if (wr) begin
            if (hit_clks) begin
                clks_r <= i_pwdata[7:0];
            end
            if (hit_supply) begin
                supply_r <= i_pwdata[7:0];
            end
            if (hit_blink) begin
                blink_ctl_r <= i_pwdata[7:0];
            end
        end
    end

    // read data held in a flop, loaded during the setup cycle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_prdata <= '0;
        end else if (i_ce && i_psel && !i_penable && !i_pwrite) begin
            if (hit_clks) begin
                o_prdata <= {24'h000000, clks_r};
            end else if (hit_supply) begin
                o_prdata <= {24'h000000, supply_r};
            end else if (hit_blink) begin
                o_prdata <= {24'h000000, blink_ctl_r};
            end else begin
                o_prdata <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // panel clock source and dividers
    // ------------------------------------------------------------------
    logic bus_phase_r;
    logic ext_ref_d_r;
    logic bus_tick;
    logic ext_tick;
    logic src_tick;
    logic adj_in_tick;
    logic panel_tick;
    logic pump_tick;

    // bus clock runs at half the generator output; reference is edge detected
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            bus_phase_r <= 1'b0;
            ext_ref_d_r <= 1'b0;
        end else if (i_ce) begin
            bus_phase_r <= !bus_phase_r;
            ext_ref_d_r <= i_external_reference_clock;
        end
    end

    assign bus_tick = bus_phase_r;
    assign ext_tick = i_external_reference_clock && !ext_ref_d_r;
    assign src_tick = clks_r[`CLKS_SOURCE_BIT] ? bus_tick : ext_tick;

    div_if #(.W(4)) pre_bus ();
    div_if #(.W(6)) adj_bus ();
    div_if #(.W(7)) pump_bus ();
    div_if #(.W(12)) blk_bus ();

    assign pre_bus.tick_in = src_tick;
    assign pre_bus.clear   = !clks_r[`CLKS_PRESCALE_BIT];
    assign pre_bus.limit   = 4'(`PRESCALE_DIV - 1);

    div_stage #(.W(4)) u_prescale (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .i_ce   (i_ce),
        .bus    (pre_bus)
    );

    assign adj_in_tick     = clks_r[`CLKS_PRESCALE_BIT] ? pre_bus.tick_out : src_tick;
    assign adj_bus.tick_in = adj_in_tick;
    assign adj_bus.clear   = 1'b0;
    assign adj_bus.limit   = clks_r[`CLKS_DIV_MSB:`CLKS_DIV_LSB];

    div_stage #(.W(6)) u_clkadj (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .i_ce   (i_ce),
        .bus    (adj_bus)
    );

    assign panel_tick       = adj_bus.tick_out;
    assign pump_bus.tick_in = panel_tick;
    assign pump_bus.clear   = !supply_r[`SUP_PUMP_EN_BIT];
    // six times two to the (adjust plus one): 12, 24, 48 or 96 panel ticks
    assign pump_bus.limit   = 7'((8'(`PUMP_BASE_DIV)
                              << (3'(supply_r[`SUP_PUMP_ADJ_MSB:`SUP_PUMP_ADJ_LSB]) + 3'd1))
                              - 8'd1);

    div_stage #(.W(7)) u_pump (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .i_ce   (i_ce),
        .bus    (pump_bus)
    );

    assign pump_tick = pump_bus.tick_out;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_panel_clock_tick <= 1'b0;
            o_pump_clock_tick  <= 1'b0;
        end else if (i_ce) begin
            o_panel_clock_tick <= panel_tick;
            o_pump_clock_tick  <= pump_tick;
        end
    end

    // ------------------------------------------------------------------
    // supply and bias controls
    // ------------------------------------------------------------------
    assign o_charge_pump_enable       = supply_r[`SUP_PUMP_EN_BIT];
    assign o_bias_internal            = supply_r[`SUP_PUMP_EN_BIT];
    assign o_pump_tripler             = supply_r[`SUP_PUMP_MULT_BIT];
    assign o_high_drive_buffer_select = supply_r[`SUP_HIGH_DRIVE_BIT];
    assign o_buffer_bypass            = supply_r[`SUP_BYPASS_BIT];
    assign o_supply_source_select     = supply_r[`SUP_SOURCE_MSB:`SUP_SOURCE_LSB];

    // ------------------------------------------------------------------
    // blink controller
    // ------------------------------------------------------------------
    blink_state_type blink_state_r;
    blink_state_type blink_state_nxt;
    logic            blink_phase_r;
    logic            frame_go;

    assign frame_go = i_frame_start && i_ce;

    always_comb begin
        blink_state_nxt = blink_state_r;
        case (blink_state_r)
            blink_off: begin
                if (frame_go && blink_ctl_r[`BLK_ENABLE_BIT]) begin
                    blink_state_nxt = blink_run;
                end
            end
            blink_run: begin
                if (frame_go && !blink_ctl_r[`BLK_ENABLE_BIT]) begin
                    blink_state_nxt = blink_off;
                end
            end
            default: begin
                blink_state_nxt = blink_off;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            blink_state_r <= blink_off;
        end else if (i_ce) begin
            blink_state_r <= blink_state_nxt;
        end
    end

    // half period 2^(4+rate) base ticks, full period 2^(5+rate)
    assign blk_bus.tick_in = i_wave_base_tick && (blink_state_r == blink_run);
    assign blk_bus.clear   = (blink_state_r == blink_off);
    assign blk_bus.limit   = 12'((13'h0001 << (4'(`BLINK_EXP_BASE - 1)
                             + 4'(blink_ctl_r[`BLK_RATE_MSB:`BLK_RATE_LSB]))) - 13'h0001);

    div_stage #(.W(12)) u_blink (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .i_ce   (i_ce),
        .bus    (blk_bus)
    );

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            blink_phase_r <= 1'b0;
        end else if (i_ce) begin
            if (blink_state_r == blink_off) begin
                blink_phase_r <= 1'b0;
            end else if (blk_bus.tick_out) begin
                blink_phase_r <= !blink_phase_r;
            end
        end
    end

    assign o_blink_active = (blink_state_r == blink_run);
    assign o_blink_phase  = blink_phase_r;

    // ------------------------------------------------------------------
    // segment gating
    // ------------------------------------------------------------------
    logic [N_SEG-1:0] blank_mask;

    always_comb begin
        blank_mask = '0;
        if (blink_state_r == blink_run && blink_phase_r) begin
            if (blink_ctl_r[`BLK_SCOPE_BIT]) begin
                blank_mask = '1;
            end else begin
                blank_mask = i_seg_blink_en;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_seg_drive <= '0;
        end else if (i_ce) begin
            if (!i_panel_module_enable) begin
                o_seg_drive <= '0;
            end else begin
                o_seg_drive <= i_seg_on & ~blank_mask;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_reg_write(logic [11:0] off);
        i_psel && i_penable && i_pwrite && i_ce && (i_paddr == off);
    endsequence
    sequence s_blink_read_setup;
        i_psel && !i_penable && !i_pwrite && i_ce && (i_paddr == `LCD_BLINK_OFF);
    endsequence
    sequence s_start_req;
        i_frame_start && i_ce && blink_ctl_r[`BLK_ENABLE_BIT];
    endsequence
    property p_clks_write;
        @(posedge i_clk) disable iff (i_srst)
        s_reg_write(`LCD_CLKS_OFF) |=> (clks_r == $past(i_pwdata[7:0]));
    endproperty
    a_clks_write: assert property (p_clks_write) else $error("clock source write lost");
    property p_blink_write_read;
        @(posedge i_clk) disable iff (i_srst)
        s_reg_write(`LCD_BLINK_OFF) ##2 s_blink_read_setup
        |=> (o_prdata[7:0] == $past(i_pwdata[7:0], 3)) && (o_prdata[31:8] == 24'h000000);
    endproperty
    a_blink_write_read: assert property (p_blink_write_read) else $error("blink read mismatch");
    property p_blink_only_at_frame;
        @(posedge i_clk) disable iff (i_srst)
        $changed(o_blink_active) |-> $past(i_frame_start && i_ce);
    endproperty
    a_blink_only_at_frame: assert property (p_blink_only_at_frame) else $error("blink changed off frame");
    property p_blink_start;
        @(posedge i_clk) disable iff (i_srst)
        s_start_req |=> o_blink_active;
    endproperty
    a_blink_start: assert property (p_blink_start) else $error("blink did not start");
    property p_bias_follows_pump;
        @(posedge i_clk) disable iff (i_srst)
        s_reg_write(`LCD_SUPPLY_OFF) |=> (o_bias_internal == $past(i_pwdata[7]))
            && (o_buffer_bypass == $past(i_pwdata[2]));
    endproperty
    a_bias_follows_pump: assert property (p_bias_follows_pump) else $error("bias not following pump");
    property p_direct_divide;
        @(posedge i_clk) disable iff (i_srst)
        (src_tick && i_ce && !clks_r[`CLKS_PRESCALE_BIT] && clks_r[5:0] == 6'h00)
        |=> o_panel_clock_tick;
    endproperty
    a_direct_divide: assert property (p_direct_divide) else $error("panel tick missing");
    property p_pump_needs_panel;
        @(posedge i_clk) disable iff (i_srst)
        o_pump_clock_tick |-> o_panel_clock_tick && $past(supply_r[7]);
    endproperty
    a_pump_needs_panel: assert property (p_pump_needs_panel) else $error("pump tick without panel tick");
    property p_phase_idle;
        @(posedge i_clk) disable iff (i_srst)
        (!o_blink_active && i_ce) |=> !o_blink_phase;
    endproperty
    a_phase_idle: assert property (p_phase_idle) else $error("phase moved while idle");
    property p_disabled_dark;
        @(posedge i_clk) disable iff (i_srst)
        (!i_panel_module_enable && i_ce) |=> (o_seg_drive == '0);
    endproperty
    a_disabled_dark: assert property (p_disabled_dark) else $error("segments driven while disabled");
    property p_blink_all;
        @(posedge i_clk) disable iff (i_srst)
        (o_blink_active && o_blink_phase && blink_ctl_r[3] && i_ce) |=> (o_seg_drive == '0);
    endproperty
    a_blink_all: assert property (p_blink_all) else $error("segment shown in blank phase");

endmodule // lcd_cfg

// >>> verif/panel_model.sv
`timescale 1ns/1ps

// ------------------------------------------------
// glass and bias network seen from the pump side
// ------------------------------------------------
module panel_model (
    input  wire logic i_clk,        // system clock
    input  wire logic i_pump_tick,  // pump stroke pulse
    input  wire logic i_pump_on,    // pump enabled
    output int        o_strokes     // strokes delivered
);
    int n = 0;
    // a disabled pump feeds no charge, so its strokes are not counted
    always @(posedge i_clk) begin
        if (i_pump_on && i_pump_tick) begin
            n <= n + 1;
        end
    end
    assign o_strokes = n;
endmodule // panel_model

// >>> verif/test_lcd_cfg.sv
`timescale 1ns/1ps
`include "lcd_cfg_params.svh"

module test_lcd_cfg;
    import lcd_cfg_pkg::*;
    localparam int N = 164;
    logic         i_clk = 0, i_srst = 1, i_ce = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    apb_addr_type i_paddr = '0;
    apb_data_type i_pwdata = '0;
    logic         ext = 0, en = 0, frame = 0, base = 0;
    logic [N-1:0] on_b = '0, blk_b = '0, seg;
    apb_data_type prdata, rd;
    logic         pready, pslverr, se, ptick, ktick, pump_on, bias, trip, hdrv, byp, act, ph;
    logic [1:0]   ssel;
    int           err_total = 0, check_count = 0, cyc = 0, pn = 0, ec = 0, bc = 0, strokes;

    lcd_cfg #(.N_SEG(N)) u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_external_reference_clock(ext),
        .i_panel_module_enable(en), .i_frame_start(frame), .i_wave_base_tick(base), .i_seg_on(on_b),
        .i_seg_blink_en(blk_b), .o_panel_clock_tick(ptick), .o_pump_clock_tick(ktick),
        .o_charge_pump_enable(pump_on), .o_bias_internal(bias), .o_pump_tripler(trip),
        .o_high_drive_buffer_select(hdrv), .o_buffer_bypass(byp), .o_supply_source_select(ssel),
        .o_blink_active(act), .o_blink_phase(ph), .o_seg_drive(seg));
    panel_model u_panel (.i_clk(i_clk), .i_pump_tick(ktick), .i_pump_on(pump_on), .o_strokes(strokes));

    // ------------------------------------------------
    // clock, reference clock, base ticks, timeout
    // ------------------------------------------------
    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        pn <= pn + int'(ptick);
        ec <= (ec == 4) ? 0 : ec + 1;
        ext <= (ec == 4) ? ~ext : ext;
        bc <= (bc == 3) ? 0 : bc + 1;
        base <= (bc == 3);
        if (cyc == 80000) begin
            err_total++;
            wrap_up();
        end
    end

    // ------------------------------------------------
    // compares and bus cycles
    // ------------------------------------------------
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_near(string what, int exp, int got);
        check_count++;
        if (got < exp - 1 || got > exp + 1) begin
            err_total++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic chk_seg(string what, logic [N-1:0] exp, logic [N-1:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(logic w, apb_addr_type a, logic [7:0] d);
        @(posedge i_clk);
        i_psel <= 1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= {24'h0, d};
        @(posedge i_clk);
        i_penable <= 1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        i_psel <= 0;
        i_penable <= 0;
    endtask
    task automatic pulse_frame();
        @(posedge i_clk);
        frame <= 1;
        @(posedge i_clk);
        frame <= 0;
        repeat (2) @(posedge i_clk);
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_regs();
        apb_addr_type adr [3] = '{`LCD_CLKS_OFF, `LCD_SUPPLY_OFF, `LCD_BLINK_OFF};
        for (int i = 0; i < 3; i++) begin
            apb(0, adr[i], 8'h00);
            chk("reset value", 32'h0, rd);
            apb(1, adr[i], 8'h35 + 8'(i));
            apb(0, adr[i], 8'h00);
            chk("readback", 32'h35 + 32'(i), rd);
        end
        apb(0, 12'h00c, 8'h00);
        chk("unmapped error", 32'h1, 32'(se));
        chk("unmapped data", 32'h0, rd);
    endtask
    task automatic t_supply();
        logic [7:0] v [2] = '{8'hf6, 8'h09};
        for (int i = 0; i < 2; i++) begin
            apb(1, `LCD_SUPPLY_OFF, v[i]);  // written while module disabled
            @(posedge i_clk);
            chk("pump enable", 32'(v[i][7]), 32'(pump_on));
            chk("internal bias", 32'(v[i][7]), 32'(bias));
            chk("tripler", 32'(v[i][6]), 32'(trip));
            chk("high drive", 32'(v[i][3]), 32'(hdrv));
            chk("bypass", 32'(v[i][2]), 32'(byp));
            chk("supply code", 32'(v[i][1:0]), 32'(ssel));
        end
    endtask
    task automatic rate(logic [7:0] cfg, int win, int exp);
        int a;
        apb(1, `LCD_CLKS_OFF, cfg);  // module enable held low
        repeat (200) @(posedge i_clk);
        a = pn;
        repeat (win) @(posedge i_clk);
        chk_near("panel ticks", exp, pn - a);
    endtask
    task automatic t_pump();
        int a;
        apb(1, `LCD_CLKS_OFF, 8'h80);
        for (int j = 0; j < 4; j++) begin
            apb(1, `LCD_SUPPLY_OFF, {2'b10, 2'(j), 4'h0});
            repeat (400) @(posedge i_clk);
            a = strokes;
            repeat (120 << (j + 1)) @(posedge i_clk);
            chk_near("pump strokes", 10, strokes - a);
        end
    endtask
    task automatic t_freeze();
        int a;
        logic p0;
        i_ce <= 0;
        @(posedge i_clk);
        a = pn;
        p0 = ptick;
        repeat (40) @(posedge i_clk);
        chk("ready while frozen", 32'h0, 32'(pready));
        chk_near("frozen ticks", 40 * int'(p0), pn - a);
        chk("tick held", 32'(p0), 32'(ptick));
        i_ce <= 1;
    endtask
    task automatic t_blink();
        int n;
        logic [2:0] rp = 3'h0;
        en <= 1;
        on_b <= {41{4'b0111}};
        blk_b <= {82{2'b01}};
        for (int r = 0; r < 8; r++) begin
            apb(1, `LCD_BLINK_OFF, {4'h0, rp[0], rp});  // stop first, rate and scope kept
            pulse_frame();
            apb(1, `LCD_BLINK_OFF, 8'h08);
            repeat (3) @(posedge i_clk);
            chk("idle phase", 32'h0, 32'(ph));
            chk_seg("idle image", on_b, seg);
            apb(1, `LCD_BLINK_OFF, {1'b1, 3'b000, r[0], r[2:0]});
            repeat (3) @(posedge i_clk);
            chk("waits for frame", 32'h0, 32'(act));
            pulse_frame();
            chk("blink active", 32'h1, 32'(act));
            while (ph !== 1'b1) @(posedge i_clk);
            repeat (2) @(posedge i_clk);
            chk_seg("blank half", r[0] ? '0 : (on_b & ~blk_b), seg);
            n = 2;
            while (ph === 1'b1) begin
                @(posedge i_clk);
                n++;
            end
            chk("half period", 32'(64 << r), 32'(n));
            rp = 3'(r);
        end
        en <= 0;
        repeat (3) @(posedge i_clk);
        chk_seg("module off", '0, seg);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge i_clk);
        i_srst <= 0;
        t_regs();
        t_supply();
        rate(8'h82, 600, 100);
        rate(8'hc0, 640, 20);
        rate(8'h01, 400, 20);
        rate(8'hef, 15360, 10);  // bus clock over 16 over 48, near 32.768 kHz
        t_pump();
        t_freeze();
        t_blink();
        wrap_up();
    end
endmodule // test_lcd_cfg
